/* shared/spg_params.svh */
`ifndef SPG_PARAMS_SVH
`define SPG_PARAMS_SVH
// Behaviour
// - Two 4-bit pattern channels change outputs on a timer shift trigger or, outside pattern mode, on a data register write.
// - Channel zero takes its trigger from timer 0, timer 1 or the wide timer.
// - Channels run independently; one control register sets each channel's mode.
// - Data register holds latch in bits 7..4, alternate in bits 3..0.
// - Reading port bits assigned to pattern output returns the latch value.
// - Pattern mode blocks latch writes; only the alternate register is written.
// - Pattern mode otherwise shifts exactly like 1-2 step excitation.
// - Each port bit selects general port use or pattern output individually.
// - 1-step and 2-step modes rotate the 4-bit latch on each rising trigger edge.
// - Direction 0 rotates from lowest phase upward, direction 1 rotates downward.
// - 1-step and 2-step modes leave the alternate register untouched.
// - 1-2 step mode shifts latch and alternate together in the set direction.
`define SPG_OFS_CTRL  8'h4A
`define SPG_OFS_DATA0 8'h4C
`define SPG_OFS_DATA1 8'h4D
`define SPG_OFS_TSEL  8'h4E
`define SPG_OFS_FSEL  8'h4F
`define SPG_OFS_PORT  8'h50
`define SPG_CTRL_M0   0
`define SPG_CTRL_CHANNEL_ZERO_DIRECTION 1
`define SPG_CTRL_CHANNEL_ZERO_PATTERN_SELECT 2
`define SPG_CTRL_M1   4
`define SPG_CTRL_CHANNEL_ONE_DIRECTION 5
`define SPG_CTRL_CHANNEL_ONE_PATTERN_SELECT 6
`define SPG_TSEL0     1:0
`define SPG_TSEL1     5:4
`define SPG_LATCH     7:4
`define SPG_ALT       3:0
`define SPG_CH0_BITS  3:0
`define SPG_CH1_BITS  7:4
`define SPG_RST_BYTE  8'h00
`define SPG_RST_NIB   4'h0
`define SPG_RST_TSEL  8'h00
`define SPG_RST_SRC   3'h0
`endif

/* shared/spg_pkg.sv */
package spg_pkg;
  typedef enum logic [1:0] {
    SRC_T0   = 2'b00,
    SRC_T1   = 2'b01,
    SRC_WIDE = 2'b10,
    SRC_NONE = 2'b11
  } spg_src_e;
  typedef logic [3:0] spg_nib_t;
endpackage : spg_pkg

/* design/spg_channel.sv */
`include "spg_params.svh"
module spg_channel (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             shift,
  input  wire logic             step12,
  input  wire logic             rev,
  input  wire logic             pat,
  input  wire logic             wr,
  input  wire logic [7:0]       wdata,
  output spg_pkg::spg_nib_t     latch,
  output spg_pkg::spg_nib_t     alt
);
  spg_pkg::spg_nib_t latch_r;
  spg_pkg::spg_nib_t latch_nxt;
  spg_pkg::spg_nib_t alt_r;
  spg_pkg::spg_nib_t alt_nxt;
  logic [7:0]        ring;
  logic [7:0]        ring_rot;

  // Interleaved ring, high end first: L3 A3 L2 A2 L1 A1 L0 A0.
  assign ring = {latch_r[3], alt_r[3], latch_r[2], alt_r[2],
                 latch_r[1], alt_r[1], latch_r[0], alt_r[0]};

  always_comb
  begin
    ring_rot  = rev ? {ring[0], ring[7:1]} : {ring[6:0], ring[7]};
    latch_nxt = latch_r;
    alt_nxt   = alt_r;
    if (shift)
    begin
      if (step12 || pat)
      begin
        latch_nxt = {ring_rot[7], ring_rot[5], ring_rot[3], ring_rot[1]};
        alt_nxt   = {ring_rot[6], ring_rot[4], ring_rot[2], ring_rot[0]};
      end
      else
      begin
        latch_nxt = rev ? {latch_r[0], latch_r[3:1]}
                        : {latch_r[2:0], latch_r[3]};
      end
    end
    // A write in the same cycle as a shift overrides the shifted value, except the latch in pattern mode, which keeps its shift.
    if (wr)
    begin
      alt_nxt = wdata[`SPG_ALT];
      if (!pat)
      begin
        latch_nxt = wdata[`SPG_LATCH];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_r <= `SPG_RST_NIB;
      alt_r   <= `SPG_RST_NIB;
    end
    else
    begin
      latch_r <= latch_nxt;
      alt_r   <= alt_nxt;
    end
  end

  assign latch = latch_r;
  assign alt   = alt_r;
endmodule : spg_channel

/* design/spg_top.sv */
`include "spg_params.svh"
module spg_top (
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       TRIG_T0,
  input  wire logic       TRIG_T1,
  input  wire logic       TRIG_WIDE,
  output logic      [7:0] PORT_OUT
);
  logic [7:0]        ctrl_r;
  logic [7:0]        ctrl_nxt;
  logic [7:0]        tsel_r;
  logic [7:0]        tsel_nxt;
  logic [7:0]        fsel_r;
  logic [7:0]        fsel_nxt;
  logic [7:0]        gport_r;
  logic [7:0]        gport_nxt;
  logic [2:0]        trig_v;
  logic [2:0]        prev_r;
  logic [2:0]        prev_nxt;
  logic [2:0]        rise;
  logic              shift0;
  logic              shift1;
  logic              wr0;
  logic              wr1;
  spg_pkg::spg_nib_t lat0;
  spg_pkg::spg_nib_t lat1;
  spg_pkg::spg_nib_t alt0;
  spg_pkg::spg_nib_t alt1;
  logic [7:0]        pg;
  logic [7:0]        port_r;
  logic [7:0]        port_nxt;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;

  // Picks the rising trigger edge of the source a select field names.
  function automatic logic pick_src(input logic [1:0] sel,
                                    input logic [2:0] ev);
    case (spg_pkg::spg_src_e'(sel))
      spg_pkg::SRC_T0:   pick_src = ev[0];
      spg_pkg::SRC_T1:   pick_src = ev[1];
      spg_pkg::SRC_WIDE: pick_src = ev[2];
      default:           pick_src = 1'b0;
    endcase
  endfunction : pick_src

  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    tsel_nxt  = tsel_r;
    fsel_nxt  = fsel_r;
    gport_nxt = gport_r;
    if (WR)
    begin
      case (ADDR)
        `SPG_OFS_CTRL: ctrl_nxt  = WDATA;
        `SPG_OFS_TSEL: tsel_nxt  = WDATA;
        `SPG_OFS_FSEL: fsel_nxt  = WDATA;
        `SPG_OFS_PORT: gport_nxt = WDATA;
        default:       ctrl_nxt  = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl_r  <= `SPG_RST_BYTE;
      tsel_r  <= `SPG_RST_TSEL;
      fsel_r  <= `SPG_RST_BYTE;
      gport_r <= `SPG_RST_BYTE;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      tsel_r  <= tsel_nxt;
      fsel_r  <= fsel_nxt;
      gport_r <= gport_nxt;
    end
  end

  // Triggers come from timer logic on MCLK, so no synchroniser is needed.
  assign trig_v   = {TRIG_WIDE, TRIG_T1, TRIG_T0};
  assign prev_nxt = trig_v;

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      prev_r <= `SPG_RST_SRC;
    end
    else
    begin
      prev_r <= prev_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_edge
      assign rise[gi] = trig_v[gi] & ~prev_r[gi];
    end
  endgenerate

  assign shift0 = pick_src(tsel_r[`SPG_TSEL0], rise);
  assign shift1 = pick_src(tsel_r[`SPG_TSEL1], rise);
  assign wr0    = WR && (ADDR == `SPG_OFS_DATA0);
  assign wr1    = WR && (ADDR == `SPG_OFS_DATA1);

  spg_channel u_ch0 (
    .clk    (MCLK),
    .rst_n  (RESET_N),
    .shift  (shift0),
    .step12 (ctrl_r[`SPG_CTRL_M0]),
    .rev    (ctrl_r[`SPG_CTRL_CHANNEL_ZERO_DIRECTION]),
    .pat    (ctrl_r[`SPG_CTRL_CHANNEL_ZERO_PATTERN_SELECT]),
    .wr     (wr0),
    .wdata  (WDATA),
    .latch  (lat0),
    .alt    (alt0)
  );

  spg_channel u_ch1 (
    .clk    (MCLK),
    .rst_n  (RESET_N),
    .shift  (shift1),
    .step12 (ctrl_r[`SPG_CTRL_M1]),
    .rev    (ctrl_r[`SPG_CTRL_CHANNEL_ONE_DIRECTION]),
    .pat    (ctrl_r[`SPG_CTRL_CHANNEL_ONE_PATTERN_SELECT]),
    .wr     (wr1),
    .wdata  (WDATA),
    .latch  (lat1),
    .alt    (alt1)
  );

  assign pg = {lat1, lat0};

  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_port
      assign port_nxt[gi] = fsel_r[gi] ? pg[gi] : gport_r[gi];
    end
  endgenerate

  always_comb
  begin
    rdata_nxt = `SPG_RST_BYTE;
    if (RD)
    begin
      case (ADDR)
        `SPG_OFS_CTRL:  rdata_nxt = ctrl_r;
        `SPG_OFS_DATA1: rdata_nxt = {`SPG_RST_NIB, alt1};
        `SPG_OFS_TSEL:  rdata_nxt = tsel_r;
        `SPG_OFS_FSEL:  rdata_nxt = fsel_r;
        `SPG_OFS_PORT:  rdata_nxt = port_nxt;
        default:        rdata_nxt = `SPG_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      port_r  <= `SPG_RST_BYTE;
      rdata_r <= `SPG_RST_BYTE;
    end
    else
    begin
      port_r  <= port_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign PORT_OUT = port_r;
  assign RDATA    = rdata_r;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  src_t1_edge_a: assert property (
    (tsel_r[`SPG_TSEL0] == spg_pkg::SRC_T1) && TRIG_T1 && !prev_r[1]
    |-> shift0)
    else $error("Channel zero missed a timer 1 trigger edge.");

  wide_edge_only_a: assert property (
    (tsel_r[`SPG_TSEL1] == spg_pkg::SRC_WIDE) && shift1
    |-> TRIG_WIDE && !$past(TRIG_WIDE))
    else $error("Channel one shifted without a wide timer edge.");

  hold_no_trig_a: assert property (
    !shift0 && !wr0 |=> (lat0 == $past(lat0)) && (alt0 == $past(alt0)))
    else $error("Channel zero changed without trigger or write.");

  latch_write_a: assert property (
    wr0 && !ctrl_r[`SPG_CTRL_CHANNEL_ZERO_PATTERN_SELECT]
    |=> (lat0 == $past(WDATA[`SPG_LATCH]))
        && (alt0 == $past(WDATA[`SPG_ALT])))
    else $error("Channel zero data write not stored in place.");

  pat_block_a: assert property (
    wr0 && ctrl_r[`SPG_CTRL_CHANNEL_ZERO_PATTERN_SELECT] && !shift0
    |=> (lat0 == $past(lat0)) && (alt0 == $past(WDATA[`SPG_ALT])))
    else $error("Pattern mode let a latch write through.");

  pat_shift_a: assert property (
    shift0 && !wr0 && ctrl_r[`SPG_CTRL_CHANNEL_ZERO_PATTERN_SELECT]
    && !ctrl_r[`SPG_CTRL_CHANNEL_ZERO_DIRECTION]
    |=> (lat0 == $past(alt0))
        && (alt0 == {$past(lat0[2:0]), $past(lat0[3])}))
    else $error("Pattern mode shift differs from 1-2 step.");

  fwd_step_a: assert property (
    shift0 && !wr0 && !ctrl_r[`SPG_CTRL_M0] && !ctrl_r[`SPG_CTRL_CHANNEL_ZERO_PATTERN_SELECT]
    && !ctrl_r[`SPG_CTRL_CHANNEL_ZERO_DIRECTION]
    |=> lat0 == {$past(lat0[2:0]), $past(lat0[3])})
    else $error("Forward step rotation wrong.");

  rev_step_a: assert property (
    shift0 && !wr0 && !ctrl_r[`SPG_CTRL_M0] && !ctrl_r[`SPG_CTRL_CHANNEL_ZERO_PATTERN_SELECT]
    && ctrl_r[`SPG_CTRL_CHANNEL_ZERO_DIRECTION]
    |=> lat0 == {$past(lat0[0]), $past(lat0[3:1])})
    else $error("Reverse step rotation wrong.");

  alt_ignored_a: assert property (
    shift0 && !wr0 && !ctrl_r[`SPG_CTRL_M0] && !ctrl_r[`SPG_CTRL_CHANNEL_ZERO_PATTERN_SELECT]
    |=> alt0 == $past(alt0))
    else $error("Alternate register moved in 1 or 2 step mode.");

  ring_rev_a: assert property (
    shift1 && !wr1 && ctrl_r[`SPG_CTRL_M1] && ctrl_r[`SPG_CTRL_CHANNEL_ONE_DIRECTION]
    |=> (alt1 == $past(lat1))
        && (lat1 == {$past(alt1[0]), $past(alt1[3:1])}))
    else $error("Reverse 1-2 step ring shift wrong.");

  port_read_a: assert property (
    RD && (ADDR == `SPG_OFS_PORT) && fsel_r[0] && !shift0
    |=> RDATA[0] == $past(lat0[0]))
    else $error("Port read did not return the pattern latch.");

  port_out_a: assert property (
    fsel_r[7] |=> PORT_OUT[7] == $past(lat1[3]))
    else $error("Selected port bit not driven from pattern latch.");

  ring_cov_c: cover property (shift0 && ctrl_r[`SPG_CTRL_M0]);
  pat_wr_c: cover property (wr0 && ctrl_r[`SPG_CTRL_CHANNEL_ZERO_PATTERN_SELECT]);
  rev_cov_c: cover property (shift1 && ctrl_r[`SPG_CTRL_CHANNEL_ONE_DIRECTION]);
  both_cov_c: cover property (shift0 && shift1);
endmodule : spg_top

/* bench/spg_motor_model.sv */
module spg_motor_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] phase,
  output int              steps0,
  output int              steps1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] prev_r;
  // Each change of a coil nibble is taken by the driver stage as one step.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_r <= 8'h00;
      steps0 <= 0;
      steps1 <= 0;
    end
    else
    begin
      prev_r <= phase;
      if (phase[3:0] != prev_r[3:0])
        steps0 <= steps0 + 1;
      if (phase[7:4] != prev_r[7:4])
        steps1 <= steps1 + 1;
    end
  end
endmodule : spg_motor_model

/* bench/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       MCLK, RESET_N, WR, RD;
  logic [7:0] ADDR, WDATA, RDATA, PORT_OUT, rv, gen, fsel, ctrl, tsel;
  logic [2:0] trg;
  logic [7:0] e [2];
  int         error_cnt, n_checks, s0, steps0, steps1;
  spg_top dut (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .TRIG_T0(trg[0]), .TRIG_T1(trg[1]),
    .TRIG_WIDE(trg[2]), .PORT_OUT(PORT_OUT));
  spg_motor_model mot (.clk(MCLK), .rst_n(RESET_N), .phase(PORT_OUT),
    .steps0(steps0), .steps1(steps1));
  initial
  begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  task chk(input logic [7:0] s, input logic [7:0] x);
    n_checks++;
    if (s !== x)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask : rd
  // Writes a data register and tracks what the channel should now hold.
  task wd(input int c, input logic [7:0] v);
    wr(8'h4C + 8'(c), v);
    e[c] = ctrl[4*c+2] ? {e[c][7:4], v[3:0]} : v;
  endtask : wd
  function automatic logic [7:0] nx(input logic [7:0] v, input logic s12,
                                    input logic rev);
    logic [3:0] l;
    logic [3:0] a;
    l = v[7:4];
    a = v[3:0];
    if (s12)
      return rev ? {a[0], a[3:1], l} : {a, l[2:0], l[3]};
    return rev ? {l[0], l[3:1], a} : {l[2:0], l[3], a};
  endfunction : nx
  task port_chk;
    logic [7:0] x;
    x = (fsel & {e[1][7:4], e[0][7:4]}) | (~fsel & gen);
    repeat (3) @(posedge MCLK);
    #1 chk(PORT_OUT, x);
    rd(8'h50);
    chk(rv, x);
  endtask : port_chk
  task pulse(input int s);
    @(posedge MCLK);
    trg[s] <= 1'b1;
    @(posedge MCLK);
    trg[s] <= 1'b0;
    for (int c = 0; c < 2; c++)
      if (tsel[4*c+:2] == 2'(s))
        e[c] = nx(e[c], ctrl[4*c] | ctrl[4*c+2], ctrl[4*c+1]);
    port_chk();
  endtask : pulse
  task conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  initial
  begin
    #20us;
    error_cnt++;
    conclude();
  end
  initial
  begin
    RESET_N = 1'b0;
    {WR, RD, trg, ADDR, WDATA} = '0;
    {gen, fsel, ctrl, tsel} = '0;
    e = '{default: 8'h00};
    repeat (5) @(posedge MCLK);
    RESET_N <= 1'b1;
    rd(8'h4D);
    chk(rv, 8'h00);
    rd(8'h4C);
    chk(rv, 8'h00);
    rd(8'h10);
    chk(rv, 8'h00);
    chk(PORT_OUT, 8'h00);
    fsel = 8'hFF;
    wr(8'h4F, fsel);
    tsel = 8'h10;
    wr(8'h4E, tsel);
    wd(0, 8'h10);
    wd(1, 8'h35);
    port_chk();
    repeat (4) pulse(0);
    pulse(1);
    rd(8'h4D);
    chk(rv, 8'h05);
    ctrl = 8'h02;
    wr(8'h4A, ctrl);
    repeat (2) pulse(0);
    foreach (e[i])
    begin
      for (int d = 0; d < 2; d++)
      begin
        ctrl = 8'({d[0], 1'b1}) << (4 * i);
        wr(8'h4A, ctrl);
        wd(i, i == 0 ? 8'hC8 : 8'h37);
        port_chk();
        s0 = i == 0 ? steps0 : steps1;
        repeat (8) pulse(i);
        chk(PORT_OUT[4*i+:4], i == 0 ? 4'hC : 4'h3);
        chk(8'((i == 0 ? steps0 : steps1) - s0), 8'h08);
      end
    end
    ctrl = 8'h55;
    wr(8'h4A, ctrl);
    wd(1, 8'hF5);
    wd(0, 8'hF3);
    port_chk();
    rd(8'h4D);
    chk(rv, 8'h05);
    pulse(1);
    wd(1, 8'h0A);
    pulse(1);
    for (int s = 0; s < 4; s++)
    begin
      tsel = {2'b00, 2'(s), 2'b00, 2'(s)};
      wr(8'h4E, tsel);
      for (int t = 0; t < 3; t++)
        pulse(t);
    end
    fsel = 8'h0F;
    wr(8'h4F, fsel);
    gen = 8'hA5;
    wr(8'h50, gen);
    port_chk();
    conclude();
  end
endmodule : testbench
